//--- shared/sfsp_pkg.sv
// constants, types and reset state of the serial flash status/protect block
package sfsp_pkg;

    localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_STATUS_READ   = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE  = 8'h01;
    localparam logic [7:0] CMD_PAGE_PROGRAM  = 8'h02;
    localparam logic [7:0] CMD_SECTOR_ERASE  = 8'hd8;
    localparam logic [7:0] CMD_BULK_ERASE    = 8'hc7;
    localparam logic [7:0] CMD_WAKE_ID       = 8'hab;
    localparam logic [7:0] CMD_MAKER_PART    = 8'h90;
    localparam logic [7:0] ID_START_PART     = 8'h01;

    // byte counts at deselect, at the id header end and at counter saturation
    localparam logic [2:0] LEN_SHORT   = 3'h1;
    localparam logic [2:0] LEN_SWRITE  = 3'h2;
    localparam logic [2:0] LEN_ID_HDR  = 3'h3;
    localparam logic [2:0] LEN_SECTOR  = 3'h4;
    localparam logic [2:0] LEN_PROGRAM = 3'h5;
    localparam logic [2:0] LEN_SAT     = 3'h7;

    // status layout
    localparam int BUSY_POS = 0;
    localparam int WEL_POS  = 1;
    localparam int BP_LSB   = 2;
    localparam int SRP_POS  = 7;

    localparam logic [1:0] BP_RESET  = 2'h0;
    localparam logic       SRP_RESET = 1'b0;

    // timing
    localparam longint unsigned CLK_PERIOD_NS = 50;
    localparam longint unsigned T_W_US  = 10000;
    localparam longint unsigned T_PP_US = 5000;
    localparam longint unsigned T_SE_US = 1000000;
    localparam longint unsigned T_BE_US = 2000000;
    localparam longint unsigned CYC_W  = T_W_US * 1000 / CLK_PERIOD_NS;
    localparam longint unsigned CYC_PP = T_PP_US * 1000 / CLK_PERIOD_NS;
    localparam longint unsigned CYC_SE = T_SE_US * 1000 / CLK_PERIOD_NS;
    localparam longint unsigned CYC_BE = T_BE_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        TX_STATUS  = 2'b00,
        TX_PART    = 2'b01,
        TX_ID_PAIR = 2'b10
    } sfsp_tx_t;

    typedef enum logic [1:0] {
        OP_STATUS_WR = 2'b00,
        OP_PROGRAM   = 2'b01,
        OP_SECTOR    = 2'b10,
        OP_BULK      = 2'b11
    } sfsp_op_t;

    typedef struct packed {
        logic        sclk_q;
        logic        cs_q;
        logic [2:0]  bit_cnt;
        logic [2:0]  byte_cnt;
        logic [7:0]  sh_in;
        logic [7:0]  cmd;
        logic [7:0]  wdata;
        logic [7:0]  sh_out;
        logic        tx_en;
        sfsp_tx_t    tx_mode;
        logic        id_sel;
        logic        write_enable_latch;
        logic [1:0]  bp;
        logic        status_protect_bit;
        logic        busy;
        sfsp_op_t    op;
        logic [31:0] busy_cnt;
        logic        so;
        logic        so_oe;
    } sfsp_state_t;

    localparam sfsp_state_t STATE_RESET = '{
        sclk_q: 1'b0, cs_q: 1'b1, bit_cnt: 3'h0, byte_cnt: 3'h0,
        sh_in: 8'h00, cmd: 8'h00, wdata: 8'h00, sh_out: 8'h00,
        tx_en: 1'b0, tx_mode: TX_STATUS, id_sel: 1'b0, write_enable_latch: 1'b0,
        bp: BP_RESET, status_protect_bit: SRP_RESET, busy: 1'b0, op: OP_STATUS_WR,
        busy_cnt: 32'h0, so: 1'b0, so_oe: 1'b0};

endpackage

//--- hdl/sfsp_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module sfsp_sync
    import sfsp_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
)(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } sfsp_sync_t;

    sfsp_sync_t s;
    sfsp_sync_t n;

    always_comb
    begin
        n    = s;
        n.s1 = din;
        n.s2 = s.s1;
        n.s3 = s.s2;
        // first stage feeds only the second
        if (s.s2 == s.s3)
        begin
            n.q = s.s3;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end
        else
        begin
            s <= n;
        end
    end

    assign dout = s.q;

endmodule

//--- hdl/sfsp_core.sv
// status register, write latch and protection logic of the serial flash
`timescale 1ns/10ps
module sfsp_core
    import sfsp_pkg::*;
#(
    parameter logic [7:0]  MAKER_CODE = 8'h5a, // arbitrary value
    parameter logic [7:0]  PART_CODE  = 8'ha5, // arbitrary value
    parameter logic [31:0] W_CYCLES   = 32'(CYC_W),
    parameter logic [31:0] PP_CYCLES  = 32'(CYC_PP),
    parameter logic [31:0] SE_CYCLES  = 32'(CYC_SE),
    parameter logic [31:0] BE_CYCLES  = 32'(CYC_BE)
)(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic serial_in,
    input  wire logic wp_n,
    output logic      serial_out,
    output logic      serial_out_oe
);

    logic        sclk_f;
    logic        cs_f;
    logic        si_f;
    logic        wp_f;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_rise;
    logic        aligned;
    logic        end_ok;
    logic        hardware_protected_mode;
    logic        do_write_enable_cmd;
    logic        do_write_disable_cmd;
    logic        do_status_write_cmd;
    logic        do_pp;
    logic        do_se;
    logic        do_be;
    logic        busy_done;
    logic [7:0]  status;
    logic [7:0]  tx_byte;
    sfsp_state_t s;
    sfsp_state_t n;

    sfsp_sync #(.RST_VAL(1'b0)) u_sync_sclk
    (
        .clock (clock),
        .rst_n (rst_n),
        .din   (sclk),
        .dout  (sclk_f)
    );

    sfsp_sync #(.RST_VAL(1'b1)) u_sync_cs
    (
        .clock (clock),
        .rst_n (rst_n),
        .din   (cs_n),
        .dout  (cs_f)
    );

    sfsp_sync #(.RST_VAL(1'b0)) u_sync_si
    (
        .clock (clock),
        .rst_n (rst_n),
        .din   (serial_in),
        .dout  (si_f)
    );

    // pin reads high until proven low, so hardware protection stays off until then
    sfsp_sync #(.RST_VAL(1'b1)) u_sync_wp
    (
        .clock (clock),
        .rst_n (rst_n),
        .din   (wp_n),
        .dout  (wp_f)
    );

    assign sclk_rise = sclk_f & ~s.sclk_q;
    assign sclk_fall = ~sclk_f & s.sclk_q;
    assign cs_rise   = cs_f & ~s.cs_q;
    assign hardware_protected_mode       = s.status_protect_bit & ~wp_f;
    assign busy_done = s.busy && (s.busy_cnt == 32'h1);

    assign status = {s.status_protect_bit, 3'b000, s.bp, s.write_enable_latch, s.busy};

    assign tx_byte = (s.tx_mode == TX_STATUS) ? status :
                     (s.tx_mode == TX_PART) ? PART_CODE :
                     (s.id_sel ? PART_CODE : MAKER_CODE);

    // write-class instructions are ignored while a cycle runs
    assign aligned = (s.bit_cnt == 3'h0);
    assign end_ok  = cs_rise && !s.busy && aligned;
    assign do_write_enable_cmd = end_ok && (s.cmd == CMD_WRITE_ENABLE)
                     && (s.byte_cnt == LEN_SHORT);
    assign do_write_disable_cmd = end_ok && (s.cmd == CMD_WRITE_DISABLE)
                     && (s.byte_cnt == LEN_SHORT);
    assign do_status_write_cmd = end_ok && (s.cmd == CMD_STATUS_WRITE)
                     && (s.byte_cnt == LEN_SWRITE)
                     && s.write_enable_latch && !hardware_protected_mode;
    assign do_pp   = end_ok && (s.cmd == CMD_PAGE_PROGRAM)
                     && (s.byte_cnt >= LEN_PROGRAM)
                     && s.write_enable_latch && (s.bp == 2'h0);
    assign do_se   = end_ok && (s.cmd == CMD_SECTOR_ERASE)
                     && (s.byte_cnt == LEN_SECTOR)
                     && s.write_enable_latch && (s.bp == 2'h0);
    assign do_be   = end_ok && (s.cmd == CMD_BULK_ERASE)
                     && (s.byte_cnt == LEN_SHORT)
                     && s.write_enable_latch && (s.bp == 2'h0);

    always_comb
    begin
        n        = s;
        n.sclk_q = sclk_f;
        n.cs_q   = cs_f;

        if (s.busy)
        begin
            if (busy_done)
            begin
                n.busy     = 1'b0;
                n.write_enable_latch      = 1'b0;
                n.busy_cnt = 32'h0;
            end
            else
            begin
                n.busy_cnt = s.busy_cnt - 32'h1;
            end
        end

        if (cs_f)
        begin
            n.bit_cnt  = 3'h0;
            n.byte_cnt = 3'h0;
            n.tx_en    = 1'b0;
            n.so_oe    = 1'b0;
        end
        else
        begin
            if (sclk_rise)
            begin
                n.sh_in   = {s.sh_in[6:0], si_f};
                n.bit_cnt = s.bit_cnt + 3'h1;
                if (s.bit_cnt == 3'h7)
                begin
                    if (s.byte_cnt != LEN_SAT)
                    begin
                        n.byte_cnt = s.byte_cnt + 3'h1;
                    end
                    if (s.byte_cnt == 3'h0)
                    begin
                        n.cmd = n.sh_in;
                        // status read is served even while busy
                        if (n.sh_in == CMD_STATUS_READ)
                        begin
                            n.tx_en   = 1'b1;
                            n.tx_mode = TX_STATUS;
                        end
                    end
                    if (s.byte_cnt == LEN_SHORT)
                    begin
                        n.wdata = n.sh_in;
                    end
                    if ((s.byte_cnt == LEN_ID_HDR)
                        && (s.cmd == CMD_WAKE_ID))
                    begin
                        n.tx_en   = 1'b1;
                        n.tx_mode = TX_PART;
                    end
                    if ((s.byte_cnt == LEN_ID_HDR)
                        && (s.cmd == CMD_MAKER_PART))
                    begin
                        n.tx_en   = 1'b1;
                        n.tx_mode = TX_ID_PAIR;
                        n.id_sel  = (n.sh_in == ID_START_PART);
                    end
                end
            end
            if (sclk_fall && s.tx_en)
            begin
                n.so_oe = 1'b1;
                if (s.bit_cnt == 3'h0)
                begin
                    n.so     = tx_byte[7];
                    n.sh_out = {tx_byte[6:0], 1'b0};
                    if (s.tx_mode == TX_ID_PAIR)
                    begin
                        n.id_sel = ~s.id_sel;
                    end
                end
                else
                begin
                    n.so     = s.sh_out[7];
                    n.sh_out = {s.sh_out[6:0], 1'b0};
                end
            end
        end

        if (do_write_enable_cmd)
        begin
            n.write_enable_latch = 1'b1;
        end
        if (do_write_disable_cmd)
        begin
            n.write_enable_latch = 1'b0;
        end
        if (do_status_write_cmd)
        begin
            // bits 6,5,4,1,0 of the data byte are not stored
            n.bp       = s.wdata[BP_LSB +: 2];
            n.status_protect_bit      = s.wdata[SRP_POS];
            n.busy     = 1'b1;
            n.busy_cnt = W_CYCLES;
            n.op       = OP_STATUS_WR;
        end
        if (do_pp)
        begin
            n.busy     = 1'b1;
            n.busy_cnt = PP_CYCLES;
            n.op       = OP_PROGRAM;
        end
        if (do_se)
        begin
            n.busy     = 1'b1;
            n.busy_cnt = SE_CYCLES;
            n.op       = OP_SECTOR;
        end
        if (do_be)
        begin
            n.busy     = 1'b1;
            n.busy_cnt = BE_CYCLES;
            n.op       = OP_BULK;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= STATE_RESET;
        end
        else
        begin
            s <= n;
        end
    end

    assign serial_out    = s.so;
    assign serial_out_oe = s.so_oe;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_wel_cycle_end: assert property (
        busy_done |=> !s.write_enable_latch && !s.busy)
        else $error("latch not cleared at cycle end");

    a_busy_in_status: assert property (
        s.busy |-> s.busy_cnt != 32'h0)
        else $error("busy flag without a running cycle");

    a_reserved_zero: assert property (
        status[6:5] == 2'b00)
        else $error("reserved status bits not zero");

    a_start_needs_wel: assert property (
        $rose(s.busy) |-> $past(s.write_enable_latch) && $past(cs_rise))
        else $error("cycle started without latch");

    a_bulk_needs_open: assert property (
        $rose(s.busy) && s.op == OP_BULK |-> $past(s.bp) == 2'h0)
        else $error("bulk erase with protect bits set");

    a_status_write_cmd_locked: assert property (
        cs_rise && hardware_protected_mode && s.cmd == CMD_STATUS_WRITE
        |=> !$rose(s.busy) && $stable(s.bp) && $stable(s.status_protect_bit))
        else $error("status write ran in protected mode");

    a_write_enable_cmd_sets: assert property (
        do_write_enable_cmd |=> s.write_enable_latch [*2])
        else $error("write enable did not set latch");

    a_write_disable_cmd_clears: assert property (
        do_write_disable_cmd |=> !s.write_enable_latch)
        else $error("write disable did not clear latch");

    a_status_write_cmd_timed: assert property (
        do_status_write_cmd |=> s.busy && s.busy_cnt == W_CYCLES)
        else $error("status write cycle not started");

    a_msb_first: assert property (
        sclk_fall && s.tx_en && !cs_f && aligned
        |=> serial_out == $past(tx_byte[7]) && serial_out_oe)
        else $error("output byte not msb first");

    a_oe_deselect: assert property (
        cs_f |=> !serial_out_oe)
        else $error("output driven while deselected");

    a_wel_frozen: assert property (
        s.busy && !busy_done |=> $stable(s.write_enable_latch))
        else $error("latch changed during a running cycle");

    a_program_open: assert property (
        $rose(s.busy) && (s.op == OP_PROGRAM || s.op == OP_SECTOR)
        |-> $past(s.bp) == 2'h0)
        else $error("program or erase with protect bits set");

    a_status_write_cmd_fields: assert property (
        do_status_write_cmd |=> s.write_enable_latch && s.bp == $past(s.wdata[BP_LSB +: 2])
        && s.status_protect_bit == $past(s.wdata[SRP_POS]))
        else $error("status write stored wrong fields");

    a_cut_rejected: assert property (
        cs_rise && !aligned && !s.busy |=> !s.busy && $stable(s.write_enable_latch))
        else $error("instruction cut off a byte boundary ran");

    a_protect_hold: assert property (
        !do_status_write_cmd |=> $stable(s.bp) && $stable(s.status_protect_bit))
        else $error("protect bits changed without status write");

    a_part_repeat: assert property (
        sclk_fall && s.tx_en && s.tx_mode == TX_PART && aligned && !cs_f
        |=> serial_out == PART_CODE[7])
        else $error("part code byte not repeated");

    a_id_alternate: assert property (
        sclk_fall && s.tx_en && s.tx_mode == TX_ID_PAIR && aligned
        && !cs_f |=> s.id_sel != $past(s.id_sel))
        else $error("maker and part codes do not alternate");

    a_shift_msb: assert property (
        sclk_rise && !cs_f |=> s.sh_in[0] == $past(si_f)
        && s.sh_in[7:1] == $past(s.sh_in[6:0]))
        else $error("input bit not shifted in msb first");

    c_read_busy: cover property (
        s.busy && s.tx_en && s.tx_mode == TX_STATUS);
    c_status_write_cmd_start: cover property (do_status_write_cmd);
    c_id_pair: cover property (
        s.tx_en && s.tx_mode == TX_ID_PAIR && sclk_fall);
    c_wake_id: cover property (s.tx_en && s.tx_mode == TX_PART);

endmodule

//--- test/sfsp_host.sv
// spi host model driving whole frames, mode 0
`timescale 1ns/10ps
module sfsp_host (
    input  wire logic clock,
    input  wire logic serial_out,
    input  wire logic serial_out_oe,
    output logic      sclk,
    output logic      cs_n,
    output logic      serial_in
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
    end

    // sample late in the high phase: the reply lags the fall by about 4.5 clocks
    task automatic frame(input int nbits, input logic [63:0] tx,
                         output logic [63:0] rx, output logic oe_all);
        rx = '0;
        oe_all = 1'b1;
        cs_n = 1'b0;
        repeat (2) @(negedge clock);
        for (int i = nbits - 1; i >= 0; i--)
        begin
            sclk = 1'b0;
            serial_in = tx[i];
            repeat (4) @(negedge clock);
            sclk = 1'b1;
            repeat (3) @(negedge clock);
            rx = {rx[62:0], serial_out};
            if (i < nbits - 8)
                oe_all = oe_all & serial_out_oe;
            @(negedge clock);
        end
        sclk = 1'b0;
        repeat (4) @(negedge clock);
        cs_n = 1'b1;
        // released data line must not keep its last level
        serial_in = ~serial_in;
        repeat (8) @(negedge clock);
    endtask
endmodule

//--- test/spi_flash_status_protect_tb_top.sv
// self-checking bench of the status and protection block
`timescale 1ns/10ps
module spi_flash_status_protect_tb_top;
    import sfsp_pkg::*;
    localparam logic [7:0]  MAKER = 8'h3c; // arbitrary value
    localparam logic [7:0]  PART  = 8'hc3; // arbitrary value
    localparam int          CYC   = 400;
    localparam logic [7:0]  OPS [10] = '{8'h06, 8'h06, 8'h06, 8'h04,
        8'h01, 8'h01, 8'h02, 8'hd8, 8'hc7, 8'h06};
    localparam int          LENS [10] = '{8, 8, 8, 8, 16, 16, 40, 32, 8, 8};
    logic clock;
    logic rst_n;
    logic wp_n;
    logic sclk;
    logic cs_n;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe;
    int   write_enable_latch, bp, status_protect_bit, busy;
    int   bad_count, samples_checked, cycles;
    int   seed = 22;

    sfsp_core #(.MAKER_CODE (MAKER), .PART_CODE (PART),
        .W_CYCLES (32'(CYC)), .PP_CYCLES (32'(CYC)),
        .SE_CYCLES (32'(CYC)), .BE_CYCLES (32'(CYC))
    ) DUT (.clock (clock), .rst_n (rst_n), .sclk (sclk), .cs_n (cs_n),
        .serial_in (serial_in), .wp_n (wp_n), .serial_out (serial_out),
        .serial_out_oe (serial_out_oe));

    sfsp_host host (.clock (clock), .serial_out (serial_out),
        .serial_out_oe (serial_out_oe), .sclk (sclk), .cs_n (cs_n),
        .serial_in (serial_in));

    initial
        clock = 1'b0;
    always #25 clock = ~clock;

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 100000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] stat();
        return {1'(status_protect_bit), 3'h0, 2'(bp), 1'(write_enable_latch), 1'(busy)};
    endfunction

    task automatic read_status(input int n);
        logic [63:0] rx;
        logic        oe;
        host.frame(8 + 8 * n, 64'(CMD_STATUS_READ) << (8 * n), rx, oe);
        for (int k = 0; k < n; k++)
            check("status", rx[8 * k +: 8], stat());
        check("masked", rx[7:0] & 8'h9f, stat() & 8'h9f);
        check("oe", {7'h00, oe}, 8'h01);
        check("oe idle", {7'h00, serial_out_oe}, 8'h00);
    endtask

    task automatic run(input logic [7:0] op, input int nbits,
                       input logic [55:0] d);
        logic [63:0] rx;
        logic        oe;
        int          nb;
        logic        ok;
        nb = nbits / 8;
        host.frame(nbits, {op, d} >> (64 - nbits), rx, oe);
        ok = (nbits % 8 == 0) && busy == 0;
        if (ok && nb == 1 && op == CMD_WRITE_ENABLE)
            write_enable_latch = 1;
        if (ok && nb == 1 && op == CMD_WRITE_DISABLE)
            write_enable_latch = 0;
        if (ok && write_enable_latch == 1 && nb == 2 && op == CMD_STATUS_WRITE
            && !(status_protect_bit == 1 && wp_n == 1'b0))
        begin
            status_protect_bit = int'(d[55]);
            bp = int'(d[51:50]);
            busy = 1;
        end
        if (ok && write_enable_latch == 1 && bp == 0 && ((op == CMD_PAGE_PROGRAM && nb >= 5)
            || (op == CMD_SECTOR_ERASE && nb == 4)
            || (op == CMD_BULK_ERASE && nb == 1)))
            busy = 1;
        if (busy == 1)
        begin
            // latch clear attempt must be ignored while busy
            host.frame(8, 64'(CMD_WRITE_DISABLE), rx, oe);
            read_status(2);
            repeat (CYC) @(negedge clock);
            busy = 0;
            write_enable_latch = 0;
        end
        read_status(1);
    endtask

    initial
    begin
        logic [63:0] rx;
        logic        oe;
        logic [55:0] d;
        int          k;
        rst_n = 1'b0;
        wp_n = 1'b1;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        repeat (6) @(negedge clock);
        read_status(3);
        $display("test reset status done");
        host.frame(48, 64'({CMD_WAKE_ID, 40'h0}), rx, oe);
        check("part", rx[15:8], PART);
        check("part", rx[7:0], PART);
        for (int b = 0; b < 3; b++)
        begin
            host.frame(64, {CMD_MAKER_PART, 16'h0, 8'(b), 32'h0}, rx, oe);
            for (int j = 0; j < 4; j++)
                check("id", rx[8 * (3 - j) +: 8],
                      ((b + j) % 2) ? PART : MAKER);
        end
        $display("test identification done");
        for (int n = 0; n < 60; n++)
        begin
            k = $unsigned($random(seed)) % 10;
            wp_n = 1'($random(seed));
            d = 56'({$random(seed), $random(seed)});
            run(OPS[k], LENS[k] + ((($random(seed) & 7) == 0) ? 3 : 0), d);
        end
        $display("test random instructions done");
        run(CMD_WRITE_ENABLE, 8, 56'h0);
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        repeat (6) @(negedge clock);
        write_enable_latch = 0;
        bp = 0;
        status_protect_bit = 0;
        read_status(1);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
